// file: rtl/hid_cfg_pkg.sv
/*
 * Shared constants and types for the configuration byte loader: byte
 * addresses, field positions, reset values, timing figures and carriers.
 * Assumes a single 125 MHz core clock.
 */
package hid_cfg_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned DEBOUNCE_STEP_MS = 15;
	localparam int unsigned WAKE_STEP_MS = 15;
	localparam int unsigned DEBOUNCE_STEP_CYC = DEBOUNCE_STEP_MS * (CLK_HZ / 1000);
	localparam int unsigned WAKE_STEP_CYC = WAKE_STEP_MS * (CLK_HZ / 1000);

	// Configuration byte addresses
	localparam int unsigned CFG_BYTES = 5;
	localparam logic [2:0] ADDR_ROLLER_OUTPUT = 3'h0;
	localparam logic [2:0] ADDR_BUTTON_MASK = 3'h1;
	localparam logic [2:0] ADDR_EXTENDED_MASK = 3'h2;
	localparam logic [2:0] ADDR_APPLICATION = 3'h3;
	localparam logic [2:0] ADDR_WAKE_POLL = 3'h4;
	localparam logic [7:0] CFG_BYTE_RESET = 8'h00;

	// Field positions
	localparam int unsigned ROLLER_COUNT_LSB = 0;
	localparam int unsigned OUTPUT_ROLE_LSB = 2;
	localparam int unsigned ROLLER_SINK_LSB = 4;
	localparam int unsigned EXTRA_BITS_LSB = 0;
	localparam int unsigned IO_MASK_LSB = 6;
	localparam int unsigned FUNCTION_LSB = 0;
	localparam int unsigned DEBOUNCE_LSB = 2;
	localparam int unsigned LED_SINK_LSB = 4;
	localparam int unsigned WAKE_INTERVAL_LSB = 0;
	localparam int unsigned WAKE_ENABLE_BIT = 3;

	// Output role codes
	localparam logic [1:0] ROLE_BOTH_OUT = 2'h0;
	localparam logic [1:0] ROLE_A_OUT = 2'h1;
	localparam logic [1:0] ROLE_BOTH_IN = 2'h3;

	// Sink current scaling
	localparam logic [3:0] ROLLER_SINK_MAX_TENTHS = 4'hA;
	localparam logic [3:0] LED_SINK_BASE_MA = 4'h2;
	localparam logic [3:0] LED_SINK_MAX_MA = 4'hA;

	// Endpoints
	localparam logic [3:0] EP_CONTROL = 4'h0;
	localparam logic [3:0] EP_INTERRUPT_IN = 4'h1;
	localparam logic [3:0] EP_MAX_PACKET = 4'h8;

	typedef enum logic [1:0] {
		FN_MOUSE = 2'h0,
		FN_RESERVED = 2'h1,
		FN_JOYSTICK = 2'h2,
		FN_GAMEPAD = 2'h3
	} func_t;

	typedef struct packed {
		logic [2:0] pair_en;
		logic out_a_is_output;
		logic out_b_is_output;
		logic [3:0] roller_sink_tenths;
		logic [7:0] btn_mask;
		logic [7:0] extra_mask;
		func_t func;
		logic [1:0] debounce_code;
		logic [3:0] led_sink_ma;
		logic wake_poll_enable;
		logic [2:0] wake_poll_interval;
	} cfg_t;

	typedef struct packed {
		logic valid;
		logic setup;
		logic dir_in;
		logic [3:0] ep;
	} token_t;

	typedef struct packed {
		logic [7:0] buttons;
		logic [7:0] extra;
	} report_t;

endpackage : hid_cfg_pkg

// file: rtl/hid_config_byte_loader.sv
/*
 * Configuration byte loader for a HID pointing controller: reads five
 * configuration bytes after reset, decodes them, answers endpoint tokens,
 * drives the two settable pins and the LED-control pin, debounces inputs
 * and runs the suspend wake poll.
 * Assumes the EEPROM read port and the USB controller share clk; pins are
 * asynchronous and are synchronised here.
 */
`timescale 1ns/10ps

module hid_pin_sync3 #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Pins in, settled levels out
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_q
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			level_q <= '1;
		end else begin
			level_q <= (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
		end
	end
endmodule : hid_pin_sync3

// Notes on behaviour
// RULE1 - Reload configuration after power-on or bus reset
// RULE2 - Bytes zero to four are configuration
// RULE3 - Two endpoints, eight-byte packets
// RULE4 - Standard requests arrive on endpoint zero
// RULE5 - Core logic runs from one clock
// RULE6 - Set report latches pin levels
// RULE7 - Output role field selects pin roles
// RULE8 - Software writes only valid role codes
// RULE9 - LED pin darkens rollers while suspended
// RULE10 - Roller count enables pairs cumulatively
// RULE11 - Roller sink code sets current
// RULE12 - Button mask includes pins in report
// RULE13 - Extra bits include roller pins
// RULE14 - Settable pins reported when inputs
// RULE15 - Function field selects operating role
// RULE16 - Debounce code sets debounce interval
// RULE17 - LED sink code sets current
// RULE18 - Wake poll enable gates polling
// RULE19 - Wake poll interval fifteen ms steps
// RULE20 - Poll checks movement, then remote wakeup
// RULE21 - Software writes zero to reserved bits
// RULE22 - Programming mode exposes serial EEPROM port
// RULE23 - Buttons active low with pull-ups
// RULE24 - Reset pin active high
// RULE25 - Decoded values held until reset
// RULE26 - Silent and released until loaded
module hid_config_byte_loader #(
	parameter int unsigned DEBOUNCE_STEP_CYCLES = hid_cfg_pkg::DEBOUNCE_STEP_CYC,
	parameter int unsigned WAKE_STEP_CYCLES = hid_cfg_pkg::WAKE_STEP_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reset_pin,
	// Configuration EEPROM read port
	output logic ee_rd,
	output logic [2:0] ee_addr,
	input wire logic ee_valid,
	input wire logic [7:0] ee_data,
	// EEPROM serial programming port
	input wire logic prog_mode_pin,
	output logic prog_sel,
	output logic prog_sclk,
	output logic prog_din,
	input wire logic prog_dout,
	// USB controller side
	input wire logic usb_bus_reset,
	input wire logic usb_suspended,
	input wire hid_cfg_pkg::token_t token,
	output logic token_ack,
	output logic token_stall,
	input wire logic set_report_valid,
	input wire logic [7:0] set_report_byte1,
	output logic ready,
	output hid_cfg_pkg::cfg_t cfg,
	output hid_cfg_pkg::report_t report,
	// Suspend wake poll
	input wire logic roller_moved,
	input wire logic pot_changed,
	output logic wake_poll,
	output logic remote_wake,
	// Pins
	input wire logic [7:0] btn_pin,
	input wire logic [5:0] quad_pin,
	input wire logic settable_out_a_i,
	output logic settable_out_a_o,
	output logic settable_out_a_oe,
	input wire logic settable_out_b_i,
	output logic settable_out_b_o,
	output logic settable_out_b_oe,
	output logic led_control_pin_o,
	output logic led_control_pin_oe
);
	typedef enum {
		ST_ISSUE,
		ST_WAIT,
		ST_DECODE,
		ST_RUN,
		ST_PROG
	} state_t;

	state_t state_q;
	logic [2:0] idx_q;
	logic [7:0] bytes_q [hid_cfg_pkg::CFG_BYTES];
	logic [17:0] pins_sync;
	logic soft_rst;
	logic prog_mode;
	logic [15:0] deb_raw;
	logic [15:0] deb_q;
	logic [31:0] deb_cnt_q;
	logic [31:0] deb_limit;
	logic [31:0] wake_cnt_q;
	logic [31:0] wake_limit;
	logic out_a_level_q;
	logic out_b_level_q;
	logic [5:0] gp_en;
	logic [7:0] b0;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [7:0] b4;

	// RULE5 pins onto clk
	// Mode pin inverted so the sync resets to its idle level
	hid_pin_sync3 #(
		.WIDTH(18)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pin_i({~prog_mode_pin, ~reset_pin, settable_out_b_i, settable_out_a_i, quad_pin,
			btn_pin}),
		.level_q(pins_sync)
	);

	// RULE24 active high pin
	assign soft_rst = ~pins_sync[16];
	assign prog_mode = ~pins_sync[17];
	// RULE23 low means pressed
	assign deb_raw = ~pins_sync[15:0];

	assign b0 = bytes_q[hid_cfg_pkg::ADDR_ROLLER_OUTPUT];
	assign b2 = bytes_q[hid_cfg_pkg::ADDR_EXTENDED_MASK];
	assign b3 = bytes_q[hid_cfg_pkg::ADDR_APPLICATION];
	assign b4 = bytes_q[hid_cfg_pkg::ADDR_WAKE_POLL];

	// RULE1 load sequencer
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			state_q <= ST_ISSUE;
			idx_q <= 3'h0;
		end else if (usb_bus_reset) begin
			state_q <= ST_ISSUE;
			idx_q <= 3'h0;
		end else begin
			unique case (state_q)
				ST_ISSUE: begin
					state_q <= prog_mode ? ST_PROG : ST_WAIT;
				end
				ST_WAIT: begin
					if (ee_valid) begin
						// RULE2 five bytes only
						if (idx_q == 3'(hid_cfg_pkg::CFG_BYTES - 1)) begin
							state_q <= ST_DECODE;
						end else begin
							state_q <= ST_ISSUE;
							idx_q <= idx_q + 3'h1;
						end
					end
				end
				ST_DECODE: begin
					state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (prog_mode) begin
						state_q <= ST_PROG;
					end
				end
				// RULE22 leaving programming reloads
				ST_PROG: begin
					if (!prog_mode) begin
						state_q <= ST_ISSUE;
						idx_q <= 3'h0;
					end
				end
			endcase
		end
	end

	// RULE2 capture config bytes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int i = 0; i < hid_cfg_pkg::CFG_BYTES; i++) begin
				bytes_q[i] <= hid_cfg_pkg::CFG_BYTE_RESET;
			end
		end else if (state_q == ST_WAIT && ee_valid) begin
			bytes_q[idx_q] <= ee_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			ee_rd <= 1'b0;
			ee_addr <= hid_cfg_pkg::ADDR_ROLLER_OUTPUT;
		end else begin
			ee_rd <= state_q == ST_ISSUE && !prog_mode && !usb_bus_reset;
			ee_addr <= idx_q;
		end
	end

	// RULE10 cumulative pair enables
	always_comb begin
		unique case (b0[hid_cfg_pkg::ROLLER_COUNT_LSB +: 2])
			2'h0: gp_en = 6'h3F;
			2'h1: gp_en = 6'h0F;
			2'h2: gp_en = 6'h03;
			default: gp_en = 6'h00;
		endcase
	end

	// RULE25 decode once per load
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg <= '0;
		end else if (state_q == ST_DECODE) begin
			cfg.pair_en <= {~gp_en[1], ~gp_en[3], ~gp_en[5]};
			// RULE7 role decode
			cfg.out_a_is_output <= b0[hid_cfg_pkg::OUTPUT_ROLE_LSB +: 2]
				!= hid_cfg_pkg::ROLE_BOTH_IN;
			cfg.out_b_is_output <= b0[hid_cfg_pkg::OUTPUT_ROLE_LSB +: 2]
				== hid_cfg_pkg::ROLE_BOTH_OUT;
			// RULE11 tenths of a milliamp
			cfg.roller_sink_tenths <= (b0[hid_cfg_pkg::ROLLER_SINK_LSB +: 4] > 4'h9) ?
				hid_cfg_pkg::ROLLER_SINK_MAX_TENTHS :
				b0[hid_cfg_pkg::ROLLER_SINK_LSB +: 4] + 4'h1;
			// RULE12 button inclusion
			cfg.btn_mask <= bytes_q[hid_cfg_pkg::ADDR_BUTTON_MASK];
			// RULE13 extra bits gated by pair use
			cfg.extra_mask <= {b2[hid_cfg_pkg::IO_MASK_LSB +: 2],
				b2[hid_cfg_pkg::EXTRA_BITS_LSB +: 6] & gp_en};
			// RULE15 function select
			cfg.func <= hid_cfg_pkg::func_t'(b3[hid_cfg_pkg::FUNCTION_LSB +: 2]);
			cfg.debounce_code <= b3[hid_cfg_pkg::DEBOUNCE_LSB +: 2];
			// RULE17 milliamps, capped
			cfg.led_sink_ma <= (b3[hid_cfg_pkg::LED_SINK_LSB +: 4] > 4'h8) ?
				hid_cfg_pkg::LED_SINK_MAX_MA :
				b3[hid_cfg_pkg::LED_SINK_LSB +: 4] + hid_cfg_pkg::LED_SINK_BASE_MA;
			cfg.wake_poll_enable <= b4[hid_cfg_pkg::WAKE_ENABLE_BIT];
			cfg.wake_poll_interval <= b4[hid_cfg_pkg::WAKE_INTERVAL_LSB +: 3];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			ready <= 1'b0;
		end else begin
			ready <= state_q == ST_RUN && !usb_bus_reset && !prog_mode;
		end
	end

	// RULE3 two endpoints answered
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			token_ack <= 1'b0;
			token_stall <= 1'b0;
		end else if (token.valid && ready) begin
			// RULE4 setup only on control endpoint
			token_ack <= token.ep == hid_cfg_pkg::EP_CONTROL ||
				(token.ep == hid_cfg_pkg::EP_INTERRUPT_IN && token.dir_in && !token.setup);
			token_stall <= !(token.ep == hid_cfg_pkg::EP_CONTROL ||
				(token.ep == hid_cfg_pkg::EP_INTERRUPT_IN && token.dir_in && !token.setup));
		end else begin
			// RULE26 no answer while loading
			token_ack <= 1'b0;
			token_stall <= 1'b0;
		end
	end

	// RULE6 latch levels from report
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst || usb_bus_reset) begin
			out_a_level_q <= 1'b1;
			out_b_level_q <= 1'b1;
		end else if (set_report_valid && ready) begin
			out_a_level_q <= set_report_byte1[0];
			out_b_level_q <= set_report_byte1[1];
		end
	end

	// RULE16 interval in fifteen ms steps
	assign deb_limit = 32'({30'h0, cfg.debounce_code} + 32'h1) * DEBOUNCE_STEP_CYCLES;

	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			deb_q <= 16'h0000;
			deb_cnt_q <= 32'h0;
		end else if (deb_raw == deb_q) begin
			deb_cnt_q <= 32'h0;
		end else if (deb_cnt_q >= deb_limit - 32'h1) begin
			deb_q <= deb_raw;
			deb_cnt_q <= 32'h0;
		end else begin
			deb_cnt_q <= deb_cnt_q + 32'h1;
		end
	end

	// RULE12 masked buttons in report
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			report <= '0;
		end else begin
			report.buttons <= deb_q[7:0] & cfg.btn_mask;
			report.extra[5:0] <= deb_q[13:8] & cfg.extra_mask[5:0];
			// RULE14 pins reported as inputs
			report.extra[6] <= deb_q[14] & cfg.extra_mask[6] & ~cfg.out_a_is_output;
			report.extra[7] <= deb_q[15] & cfg.extra_mask[7] & ~cfg.out_b_is_output;
		end
	end

	// RULE19 interval in fifteen ms steps
	assign wake_limit = 32'({29'h0, cfg.wake_poll_interval} + 32'h1) * WAKE_STEP_CYCLES;

	// RULE18 no polling unless enabled
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			wake_cnt_q <= 32'h0;
			wake_poll <= 1'b0;
		end else if (!(ready && usb_suspended && cfg.wake_poll_enable)) begin
			wake_cnt_q <= 32'h0;
			wake_poll <= 1'b0;
		end else if (wake_cnt_q >= wake_limit - 32'h1) begin
			wake_cnt_q <= 32'h0;
			wake_poll <= 1'b1;
		end else begin
			wake_cnt_q <= wake_cnt_q + 32'h1;
			wake_poll <= 1'b0;
		end
	end

	// RULE20 movement check at poll
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			remote_wake <= 1'b0;
		end else begin
			remote_wake <= wake_poll && ready && usb_suspended &&
				((cfg.func == hid_cfg_pkg::FN_MOUSE && roller_moved) ||
				(cfg.func == hid_cfg_pkg::FN_JOYSTICK && pot_changed));
		end
	end

	// RULE7 open-collector drive
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			settable_out_a_o <= 1'b0;
			settable_out_a_oe <= 1'b0;
			settable_out_b_o <= 1'b0;
			settable_out_b_oe <= 1'b0;
		end else if (state_q == ST_PROG) begin
			// RULE22 data out on pin A
			settable_out_a_o <= prog_dout;
			settable_out_a_oe <= 1'b1;
			settable_out_b_o <= 1'b0;
			settable_out_b_oe <= 1'b0;
		end else begin
			// RULE26 released until ready
			settable_out_a_o <= 1'b0;
			settable_out_a_oe <= ready && cfg.out_a_is_output && !out_a_level_q;
			settable_out_b_o <= 1'b0;
			settable_out_b_oe <= ready && cfg.out_b_is_output && !out_b_level_q;
		end
	end

	// RULE9 LED pin when not a button
	always_ff @(posedge clk) begin
		if (!reset_n || soft_rst) begin
			led_control_pin_o <= 1'b0;
			led_control_pin_oe <= 1'b0;
		end else begin
			led_control_pin_oe <= ready && !cfg.btn_mask[7];
			led_control_pin_o <= !usb_suspended;
		end
	end

	// RULE22 buttons become serial port
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prog_sel <= 1'b0;
			prog_sclk <= 1'b0;
			prog_din <= 1'b0;
		end else if (state_q == ST_PROG) begin
			prog_sel <= pins_sync[0];
			prog_sclk <= pins_sync[1];
			prog_din <= pins_sync[2];
		end else begin
			prog_sel <= 1'b0;
			prog_sclk <= 1'b0;
			prog_din <= 1'b0;
		end
	end

endmodule : hid_config_byte_loader

// file: tb/hid_config_byte_loader_sva.sv
/* Port assertions for the loader.
   Assumes pin release is judged only while the programming pin is low. */
`timescale 1ns/10ps
module hid_loader_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Watched ports
	input wire logic ee_rd,
	input wire logic [2:0] ee_addr,
	input wire logic ee_valid,
	input wire logic prog_mode_pin,
	input wire logic usb_bus_reset,
	input wire hid_cfg_pkg::token_t token,
	input wire logic token_ack,
	input wire logic token_stall,
	input wire logic ready,
	input wire hid_cfg_pkg::cfg_t cfg,
	input wire logic wake_poll,
	input wire logic remote_wake,
	input wire logic settable_out_a_oe,
	input wire logic settable_out_b_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_tok;
		token.valid && ready && !usb_bus_reset;
	endsequence
	sequence s_last_byte;
		ee_valid && ee_addr == 3'h4 && !ready ##1 !usb_bus_reset [*3];
	endsequence
	a_addr_in_range: assert property (ee_rd |-> ee_addr <= 3'h4)
		else $error("read address above four");
	a_rd_one_cycle: assert property (ee_rd |=> !ee_rd)
		else $error("read request longer than one cycle");
	a_ready_after_load: assert property (s_last_byte |=> ready)
		else $error("not ready after last byte");
	a_bus_reset_reload: assert property (usb_bus_reset |-> ##[1:2] !ready)
		else $error("bus reset kept ready");
	a_ep0_accepted: assert property (s_tok ##0 token.ep == 4'h0 |=> token_ack && !token_stall)
		else $error("endpoint zero not accepted");
	a_ep_high_stall: assert property (s_tok ##0 token.ep > 4'h1 |=> token_stall && !token_ack)
		else $error("unknown endpoint not refused");
	a_ep1_in_ack: assert property (s_tok ##0 (token.ep == 4'h1 && token.dir_in && !token.setup)
		|=> token_ack)
		else $error("endpoint one IN not accepted");
	a_silent_loading: assert property (token.valid && !ready |=> !token_ack && !token_stall)
		else $error("answer while loading");
	a_pins_released: assert property (!ready && !$past(ready) && !prog_mode_pin
		|-> !settable_out_a_oe && !settable_out_b_oe)
		else $error("pin driven while loading");
	a_cfg_held: assert property (ready && $past(ready) |-> $stable(cfg))
		else $error("decoded values moved");
	a_wake_gated: assert property (!cfg.wake_poll_enable && !$past(cfg.wake_poll_enable)
		|-> !wake_poll)
		else $error("wake poll while disabled");
	a_wake_follows: assert property (remote_wake |-> $past(wake_poll))
		else $error("remote wake without poll");
endmodule : hid_loader_sva
bind hid_config_byte_loader hid_loader_sva u_sva (.clk(clk), .reset_n(reset_n), .ee_rd(ee_rd),
	.ee_addr(ee_addr), .ee_valid(ee_valid), .prog_mode_pin(prog_mode_pin),
	.usb_bus_reset(usb_bus_reset), .token(token), .token_ack(token_ack),
	.token_stall(token_stall), .ready(ready), .cfg(cfg), .wake_poll(wake_poll),
	.remote_wake(remote_wake), .settable_out_a_oe(settable_out_a_oe),
	.settable_out_b_oe(settable_out_b_oe));

// file: tb/hid_config_byte_loader_tb.sv
/* Self-checking bench: loading, tokens, set report, pins and wake poll.
   Assumes short debounce and wake steps set through parameters. */
`timescale 1ns/10ps
module hid_config_byte_loader_tb;
	localparam int unsigned STEP = 4;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic ee_rd, ee_valid, token_ack, token_stall, ready, wake_poll, remote_wake;
	logic a_o, a_oe, b_o, b_oe, led_o, led_oe;
	logic [2:0] ee_addr;
	logic [7:0] ee_data;
	logic [39:0] image = 40'h08340F7F31;
	logic [3:0] lat = 4'h5;
	hid_cfg_pkg::token_t tok = '0;
	hid_cfg_pkg::cfg_t cfg;
	hid_cfg_pkg::report_t report;
	logic bus_rst = 1'b0;
	logic susp = 1'b0;
	logic srv = 1'b0;
	logic [7:0] srb = 8'h00;
	logic moved = 1'b0;
	logic [7:0] btn = 8'hFF;
	logic [5:0] quad = 6'h3F;
	logic [1:0] opin = 2'b11;
	logic prog = 1'b0;
	logic rst_pin = 1'b0;
	logic p_sel, p_sclk, p_din;
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	logic [7:0] w, r;
	always #4 clk = ~clk;
	hid_ee_model ee (.clk(clk), .reset_n(reset_n), .ee_rd(ee_rd), .ee_addr(ee_addr),
		.ee_valid(ee_valid), .ee_data(ee_data), .image(image), .lat(lat));
	hid_config_byte_loader #(.DEBOUNCE_STEP_CYCLES(STEP), .WAKE_STEP_CYCLES(STEP)) uut (
		.clk(clk), .reset_n(reset_n), .reset_pin(rst_pin), .ee_rd(ee_rd), .ee_addr(ee_addr),
		.ee_valid(ee_valid), .ee_data(ee_data), .prog_mode_pin(prog), .prog_sel(p_sel),
		.prog_sclk(p_sclk), .prog_din(p_din), .prog_dout(p_sclk), .usb_bus_reset(bus_rst),
		.usb_suspended(susp), .token(tok), .token_ack(token_ack), .token_stall(token_stall),
		.set_report_valid(srv), .set_report_byte1(srb), .ready(ready), .cfg(cfg),
		.report(report), .roller_moved(moved), .pot_changed(1'b0), .wake_poll(wake_poll),
		.remote_wake(remote_wake), .btn_pin(btn), .quad_pin(quad),
		.settable_out_a_i(a_oe ? a_o : opin[0]), .settable_out_a_o(a_o),
		.settable_out_a_oe(a_oe),
		.settable_out_b_i(b_oe ? b_o : opin[1]), .settable_out_b_o(b_o),
		.settable_out_b_oe(b_oe),
		.led_control_pin_o(led_o), .led_control_pin_oe(led_oe));
	task automatic conclude();
		$display("Checks %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wait_ready();
		for (int i = 0; i < 300 && ready !== 1'b1; i++)
			@(posedge clk);
		if (ready !== 1'b1) begin
			error_cnt++;
			conclude();
		end
		#1;
	endtask : wait_ready
	// Kind is setup then direction in
	task automatic send_tok(input logic [1:0] kind, input logic [3:0] ep, input logic [1:0] exp);
		logic [1:0] got;
		got = 2'b00;
		@(posedge clk);
		tok <= '{1'b1, kind[1], kind[0], ep};
		@(posedge clk);
		tok <= '0;
		#1;
		repeat (3) begin
			got |= {token_ack, token_stall};
			cyc(1);
		end
		chk(got, exp);
	endtask : send_tok
	task automatic set_rep(input logic [7:0] b);
		@(posedge clk);
		srv <= 1'b1;
		srb <= b;
		@(posedge clk);
		srv <= 1'b0;
		cyc(4);
	endtask : set_rep
	task automatic count_wake(output logic [7:0] wc, output logic [7:0] rc);
		wc = 8'h00;
		rc = 8'h00;
		repeat (40) begin
			@(posedge clk);
			#1;
			wc = wc + {7'h00, wake_poll};
			rc = rc + {7'h00, remote_wake};
		end
	endtask : count_wake
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		send_tok(2'b10, 4'h0, 2'b00);
		chk({a_oe, b_oe}, 2'b00);
		wait_ready();
		chk(cfg, hid_cfg_pkg::cfg_t'{3'h1, 1'b1, 1'b1, 4'h4, 8'h7F, 8'h0F, hid_cfg_pkg::FN_MOUSE,
			2'h1, 4'h5, 1'b1, 3'h0});
		send_tok(2'b10, 4'h0, 2'b10);
		send_tok(2'b01, 4'h1, 2'b10);
		send_tok(2'b00, 4'h1, 2'b01);
		send_tok(2'b11, 4'h1, 2'b01);
		send_tok(2'b01, 4'h2, 2'b01);
		set_rep(8'h02);
		chk({a_oe, b_oe, a_o}, 3'b100);
		chk({led_oe, led_o}, 2'b11);
		// Button 0 press settles out of the debouncer after two steps
		cyc(20);
		@(posedge clk);
		btn[0] <= 1'b0;
		for (n = 0; n < 60 && report.buttons[0] !== 1'b1; n++)
			cyc(1);
		chk(n >= 2 * STEP + 3 && n <= 2 * STEP + 6, 1'b1);
		#1;
		chk(report.buttons, 8'h01);
		@(posedge clk);
		susp <= 1'b1;
		moved <= 1'b1;
		cyc(10);
		chk({led_oe, led_o}, 2'b10);
		count_wake(w, r);
		chk(w, 40 / STEP);
		chk(r, 40 / STEP);
		@(posedge clk);
		susp <= 1'b0;
		moved <= 1'b0;
		btn <= 8'hFF;
		lat <= 4'h1;
		image <= 40'h059EC3FF9E;
		bus_rst <= 1'b1;
		@(posedge clk);
		bus_rst <= 1'b0;
		cyc(2);
		chk(ready, 1'b0);
		wait_ready();
		chk(cfg, hid_cfg_pkg::cfg_t'{3'h3, 1'b0, 1'b0, 4'hA, 8'hFF, 8'hC3,
			hid_cfg_pkg::FN_JOYSTICK, 2'h3, 4'hA, 1'b0, 3'h5});
		@(posedge clk);
		rst_pin <= 1'b1;
		cyc(8);
		chk(ready, 1'b0);
		@(posedge clk);
		rst_pin <= 1'b0;
		wait_ready();
		set_rep(8'h00);
		chk({a_oe, b_oe, led_oe}, 3'b000);
		@(posedge clk);
		quad <= 6'h3E;
		opin <= 2'b10;
		cyc(40);
		chk(report.extra, 8'h41);
		@(posedge clk);
		susp <= 1'b1;
		moved <= 1'b1;
		count_wake(w, r);
		chk(w, 0);
		@(posedge clk);
		prog <= 1'b1;
		btn <= 8'hFA;
		cyc(10);
		chk({p_sel, p_sclk, p_din, a_oe, a_o, ready}, 6'b010110);
		conclude();
	end
endmodule : hid_config_byte_loader_tb

// file: tb/hid_ee_model.sv
/* EEPROM read-port model for the loader bench.
   Assumes the loader pulses one read at a time on the shared clock. */
`timescale 1ns/10ps
module hid_ee_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Read port
	input wire logic ee_rd,
	input wire logic [2:0] ee_addr,
	output logic ee_valid,
	output logic [7:0] ee_data,
	// Contents and answer latency
	input wire logic [39:0] image,
	input wire logic [3:0] lat
);
	logic [3:0] cnt_q;
	logic [2:0] addr_q;
	always_ff @(posedge clk) begin
		ee_valid <= 1'b0;
		// Data line toggles when not answering
		ee_data <= ~ee_data;
		if (!reset_n) begin
			cnt_q <= 4'h0;
			ee_data <= 8'h00;
		end else if (ee_rd) begin
			cnt_q <= lat;
			addr_q <= ee_addr;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1) begin
				ee_valid <= 1'b1;
				ee_data <= image[addr_q*8 +: 8];
			end
		end
	end
endmodule : hid_ee_model
